// File: bench/board_model.sv
/* Board side model: strap resistors and free-running clock sources.
   Assumes the bench picks the strap levels through the req inputs. */
`timescale 1ns/1ps
module board_model (
    input wire logic reqEndian,
    input wire logic [1:0] reqBoot,
    input wire logic reqKind,
    output logic endianStrap,
    output logic fixStrap,
    output logic [1:0] bootStrap,
    output logic kindStrap,
    output logic sysClkTwo,
    output logic sysClkThree,
    output logic memClkPin,
    output logic oscClk
);
    // Strap levels, held as long as the bench keeps its request
    assign endianStrap = reqEndian;
    assign fixStrap = reqEndian;
    assign bootStrap = (reqBoot == 2'b11) ? 2'b01 : reqBoot;
    assign kindStrap = reqKind;
    // Clock generator outputs and pins, all free running
    initial begin
        sysClkTwo = 1'b0;
        sysClkThree = 1'b0;
        memClkPin = 1'b0;
        oscClk = 1'b0;
    end
    always #5 sysClkTwo = ~sysClkTwo;
    always #15 sysClkThree = ~sysClkThree;
    always #7 memClkPin = ~memClkPin;
    always #1 oscClk = ~oscClk;
endmodule

// File: bench/reset_strap_and_clock_select_bench.sv
/* Self-checking bench for the strap loader and clock select block.
   Assumes the board model drives straps and clocks; bench is Wishbone master. */
`timescale 1ns/1ps
`include "strap_cfg_consts.svh"
module reset_strap_and_clock_select_bench;
    import strap_cfg_pkg::*;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic reqEndian = 1'b1, reqKind = 1'b1, halfEn = 1'b1, pinBoard = 1'b0;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, f, e;
    logic [1:0] reqBoot = 2'b01, bootStrap;
    logic [3:0] sel = 4'hF;
    logic [31:0] adr = '0, wdat = '0, r;
    logic endianStrap, fixStrap, kindStrap, sysClkTwo, sysClkThree, memClkPin, oscClk;
    logic [31:0] datO;
    logic ack, err, fix, inval, emiClk, divClk, pinO, pinOe, pinLevel;
    byte_order_t order;
    boot_mode_t boot;
    int fail_count = 0, total_checks = 0, n;
    // Pin level: design drives when enabled, else the board
    assign pinLevel = pinOe ? pinO : pinBoard;
    always #2.5 ref_clk = ~ref_clk;
    board_model u_board_model (.reqEndian(reqEndian), .reqBoot(reqBoot), .reqKind(reqKind),
        .endianStrap(endianStrap), .fixStrap(fixStrap), .bootStrap(bootStrap),
        .kindStrap(kindStrap), .sysClkTwo(sysClkTwo), .sysClkThree(sysClkThree),
        .memClkPin(memClkPin), .oscClk(oscClk));
    reset_strap_and_clock_select u_reset_strap_and_clock_select (.ref_clk(ref_clk),
        .reset(reset), .endian_select_strap(endianStrap), .big_endian_fix_strap(fixStrap),
        .boot_select_strap(bootStrap), .input_clock_kind_strap(kindStrap),
        .system_clock_two(sysClkTwo), .system_clock_three(sysClkThree),
        .memory_clock_in_pin(memClkPin), .oscillator_clock(oscClk),
        .half_rate_out_enable(halfEn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(datO), .wb_ack_o(ack),
        .wb_err_o(err), .byte_order_mode(order), .boot_mode(boot), .big_endian_fix(fix),
        .strap_invalid(inval), .external_memory_interface_clock(emiClk),
        .divided_clock_out(divClk), .shared_pin_o(pinO), .shared_pin_oe(pinOe),
        .shared_pin_i(pinLevel));
    task automatic check(input logic [31:0] seen, input logic [31:0] expected);
        total_checks++;
        if (seen !== expected) begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, expected);
        end
    endtask
    // Classic single cycle; request held until ack or err is sampled
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
        output logic [31:0] rd, output logic er);
        int k;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (ack !== 1'b1 && err !== 1'b1 && k < 20);
        if (k == 20) fail_count++;
        rd = datO;
        er = err;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic do_reset(input logic en, input logic [1:0] b, input logic k);
        reqEndian <= en;
        reqBoot <= b;
        reqKind <= k;
        reset <= 1'b1;
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
    endtask
    // Expected strap status word
    function automatic logic [31:0] strap_word(input logic en, input logic [1:0] b,
        input logic k);
        return {26'h0, ~k, en, b, en, 1'b1};
    endfunction
    // Memory clock faster than system clock three, judged by transitions
    task automatic fast_clock(output logic fast);
        logic last;
        int c;
        c = 0;
        last = emiClk;
        repeat (500) begin
            @(posedge oscClk);
            if (emiClk !== last) c++;
            last = emiClk;
        end
        fast = c > 100;
        @(posedge ref_clk);
    endtask
    // Rising edges of the divided clock over four of its periods
    task automatic div_rises(input int ratio, output int rises);
        logic last;
        rises = 0;
        @(posedge oscClk);
        last = divClk;
        repeat (8 * (ratio + 1)) begin
            @(posedge oscClk);
            if (divClk === 1'b1 && last === 1'b0) rises++;
            last = divClk;
        end
        @(posedge ref_clk);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        #200000;
        fail_count++;
        stop_test();
    end
    initial begin
        void'($urandom(62));
        do_reset(1'b1, 2'b01, 1'b1);
        // Boot codes 00, 01, 10 with random byte order, straps moved after release
        for (int i = 0; i < 4; i++) begin
            logic ee;
            logic [1:0] bb;
            ee = 1'($urandom_range(1));
            bb = (i == 3) ? 2'b01 : i[1:0];
            do_reset(ee, bb, i != 3);
            reqEndian <= ~ee;
            reqBoot <= ~bb;
            reqKind <= 1'b1;
            repeat (3) @(posedge ref_clk);
            check(order, ee);
            check(boot, bb);
            check(fix, ee);
            check(inval, i == 3);
            bus(1'b0, `CFG_WIN_BASE + `STRAPSTAT_OFFSET, 0, r, e);
            check(r, strap_word(ee, bb, i != 3));
        end
        $display("strap test done");
        do_reset(1'b1, 2'b01, 1'b1);
        bus(1'b0, `CFG_WIN_BASE, 0, r, e);
        check(r, `CFG_WORD_RESET);
        // Source bit through random aliases, read at the last word
        for (int i = 0; i < 4; i++) begin
            logic [31:0] v;
            // Only the source bit is ever written non-zero
            v = {27'h0, ~i[0], 4'h0};
            bus(1'b1, `CFG_WIN_BASE + (32'($urandom_range(60, 4)) << 2), v, r, e);
            bus(1'b0, 32'h019C_02FC, 0, r, e);
            check(r, v);
            fast_clock(f);
            check(f, v[4]);
        end
        // Outside the window: error, no effect
        bus(1'b1, `CFG_WIN_BASE - 32'h0000_0004, 32'h0000_0010, r, e);
        check(e, 1'b1);
        bus(1'b0, `CFG_WIN_LAST + 32'h0000_0001, 0, r, e);
        check(e, 1'b1);
        bus(1'b0, `CFG_WIN_BASE, 0, r, e);
        check(r, 32'h0000_0000);
        $display("config test done");
        // Shared pin: clock mode, enable off, then general I/O
        bus(1'b0, `CFG_WIN_BASE + `PINCTL_OFFSET, 0, r, e);
        check(r & 32'h0000_00FF, `PINCTL_RESET);
        repeat (7) begin
            @(posedge ref_clk);
            check({pinOe, pinO}, {1'b1, sysClkTwo});
        end
        halfEn <= 1'b0;
        repeat (4) @(posedge ref_clk);
        check(pinOe, 1'b0);
        halfEn <= 1'b1;
        bus(1'b1, `CFG_WIN_BASE + `PINCTL_OFFSET, 32'h0000_000D, r, e);
        check({pinOe, pinO}, 2'b11);
        bus(1'b1, `CFG_WIN_BASE + `PINCTL_OFFSET, 32'h0000_0001, r, e);
        pinBoard <= 1'($urandom_range(1));
        repeat (4) @(posedge ref_clk);
        bus(1'b0, `CFG_WIN_BASE + `PINCTL_OFFSET, 0, r, e);
        check({pinOe, r[8]}, {1'b0, pinBoard});
        $display("pin test done");
        // Divided clock output at reset ratio and a random one
        bus(1'b0, `CFG_WIN_BASE + `DIVCTL_OFFSET, 0, r, e);
        check(r, `DIVCTL_RESET);
        for (int i = 0; i < 2; i++) begin
            int ratio;
            ratio = (i == 0) ? 0 : $urandom_range(7, 1);
            bus(1'b1, `CFG_WIN_BASE + `DIVCTL_OFFSET, 32'(ratio), r, e);
            div_rises(ratio, n);
            div_rises(ratio, n);
            check(n, 4);
        end
        $display("divider test done");
        stop_test();
    end
endmodule

// File: rtl/glitchless_clock_mux.sv
/*
 * Glitch-free two-input clock selector.
 * Assumes both clocks run while a switch is in progress; sel may come from
 * any domain and is synchronised into each clock here.
 */
`timescale 1ns/1ps
module glitchless_clock_mux (
    input wire logic clkA,
    input wire logic clkB,
    input wire logic reset,
    input wire logic sel,
    output logic clkOut
);
    logic aMeta;
    logic aSync;
    logic aOn;
    logic bMeta;
    logic bSync;
    logic bOn;

    // Branch A: request only once B is fully off
    always_ff @(posedge clkA) begin
        if (reset) begin
            aMeta <= 1'b1;
            aSync <= 1'b1;
        end else begin
            aMeta <= ~sel & ~bOn;
            aSync <= aMeta;
        end
    end
    // Gate updated on falling edge so the clock is low when it changes
    always_ff @(negedge clkA) begin
        if (reset) begin
            aOn <= 1'b1;
        end else begin
            aOn <= aSync;
        end
    end

    // Branch B: mirror of branch A
    always_ff @(posedge clkB) begin
        if (reset) begin
            bMeta <= 1'b0;
            bSync <= 1'b0;
        end else begin
            bMeta <= sel & ~aOn;
            bSync <= bMeta;
        end
    end
    always_ff @(negedge clkB) begin
        if (reset) begin
            bOn <= 1'b0;
        end else begin
            bOn <= bSync;
        end
    end

    // Break-before-make combine
    assign clkOut = (clkA & aOn) | (clkB & bOn);
endmodule

// File: rtl/reset_strap_and_clock_select.sv
/*
 * Reset-time configuration loader: captures board straps, holds the device
 * configuration word on a classic Wishbone slave, steers the memory clock
 * source and the two clock output pins.
 * Assumes straps are static board levels, reset is synchronous to ref_clk,
 * and the system clocks arrive from the clock generator.
 */
// The Wishbone slave port is this design's own decision.
// How it works
// - Endian strap 0 gives big-endian order, 1 gives little-endian, the default.
// - Boot straps 00 mean emulation boot, 01 8-bit ROM boot, 10 16-bit ROM boot.
// - The clock kind strap must read 1 for a square wave; a 0 is flagged as invalid.
// - Configuration bit 4 picks the memory clock: 0 system clock three, 1 the pin.
// - The shared pin carries system clock two by default or serves as I/O pin two.
// - In clock mode that pin is driven only while the half-rate enable bit is 1.
// - The divided clock output runs at a rate set by the oscillator divider.
// - The configuration register answers anywhere in 0x019C0200 to 0x019C02FF except offsets 0x04, 0x08 and 0x0C.
// - Straps are captured while reset is held and kept unchanged afterwards.
`timescale 1ns/1ps
`include "strap_cfg_consts.svh"
module reset_strap_and_clock_select #(
    parameter int DIV_WIDTH = 8
) (
    input wire logic ref_clk,
    input wire logic reset,
    // Board straps
    input wire logic endian_select_strap,
    input wire logic big_endian_fix_strap,
    input wire logic [1:0] boot_select_strap,
    input wire logic input_clock_kind_strap,
    // Clock sources
    input wire logic system_clock_two,
    input wire logic system_clock_three,
    input wire logic memory_clock_in_pin,
    input wire logic oscillator_clock,
    // Memory global control enable from the memory unit
    input wire logic half_rate_out_enable,
    // Classic Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    // Held configuration
    output strap_cfg_pkg::byte_order_t byte_order_mode,
    output strap_cfg_pkg::boot_mode_t boot_mode,
    output logic big_endian_fix,
    output logic strap_invalid,
    // Clocks and shared pin
    output logic external_memory_interface_clock,
    output logic divided_clock_out,
    output logic shared_pin_o,
    output logic shared_pin_oe,
    input wire logic shared_pin_i
);
    import strap_cfg_pkg::*;

    initial begin
        if (DIV_WIDTH < 1 || DIV_WIDTH > 8) begin
            $error("DIV_WIDTH must lie in 1..8");
        end
    end

    logic [31:0] deviceConfig;
    logic [3:0] pinControl;
    logic [DIV_WIDTH-1:0] oscillator_divider_one;
    logic [1:0] pinInSync;
    logic [1:0] enSync;
    logic resetSeen;

    // Bus decode
    wire busReq = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
    wire inWindow = (wb_adr_i & `CFG_WIN_MASK) == `CFG_WIN_BASE;
    wire [7:0] winOffset = wb_adr_i[7:0];
    wire hitPin = winOffset == `PINCTL_OFFSET;
    wire hitStat = winOffset == `STRAPSTAT_OFFSET;
    wire hitDiv = winOffset == `DIVCTL_OFFSET;
    // Any other in-window address aliases the configuration register
    wire hitCfg = inWindow & ~hitPin & ~hitStat & ~hitDiv;
    wire doWrite = busReq & inWindow & wb_we_i;
    wire wrCfg = doWrite & hitCfg & wb_sel_i[0];
    wire wrPin = doWrite & hitPin & wb_sel_i[0];
    wire wrDiv = doWrite & hitDiv & wb_sel_i[0];
    wire memClockSel = deviceConfig[`MEMCLK_SRC_BIT];
    wire gpioMode = pinControl[`PIN_GPIO_SEL_BIT];

    // Strap capture: sampled every cycle while reset is held, frozen after
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            byte_order_mode <= byte_order_t'(endian_select_strap);
            boot_mode <= boot_mode_t'(boot_select_strap);
            big_endian_fix <= big_endian_fix_strap;
            strap_invalid <= ~input_clock_kind_strap;
            resetSeen <= 1'b1;
        end
    end

    // Register writes; reserved bits are forced to zero
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            deviceConfig <= `CFG_WORD_RESET;
            pinControl <= `PINCTL_RESET;
            oscillator_divider_one <= DIV_WIDTH'(`DIVCTL_RESET);
        end else begin
            if (wrCfg) begin
                deviceConfig <= {27'h000_0000, wb_dat_i[`MEMCLK_SRC_BIT], 4'h0};
            end
            if (wrPin) begin
                pinControl <= wb_dat_i[3:0];
            end
            if (wrDiv) begin
                oscillator_divider_one <= wb_dat_i[DIV_WIDTH-1:0];
            end
        end
    end

    // Bus answer: one cycle after the request, error outside the window
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= `READ_ZERO;
        end else begin
            wb_ack_o <= busReq & inWindow;
            wb_err_o <= busReq & ~inWindow;
            if (busReq & inWindow & ~wb_we_i) begin
                if (hitCfg) begin
                    wb_dat_o <= deviceConfig;
                end else if (hitPin) begin
                    wb_dat_o <= {23'h00_0000, pinInSync[1], 4'h0, pinControl};
                end else if (hitDiv) begin
                    wb_dat_o <= {{(32-DIV_WIDTH){1'b0}}, oscillator_divider_one};
                end else begin
                    wb_dat_o <= {26'h000_0000, strap_invalid, big_endian_fix,
                        boot_mode, byte_order_mode, resetSeen};
                end
            end else begin
                wb_dat_o <= `READ_ZERO;
            end
        end
    end

    // Pin and enable synchronisers
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pinInSync <= 2'b00;
            enSync <= 2'b11;
        end else begin
            pinInSync <= {pinInSync[0], shared_pin_i};
            enSync <= {enSync[0], half_rate_out_enable};
        end
    end

    // Memory interface clock source
    glitchless_clock_mux memClockMux (
        .clkA(system_clock_three),
        .clkB(memory_clock_in_pin),
        .reset(reset),
        .sel(memClockSel),
        .clkOut(external_memory_interface_clock)
    );

    // Shared pin: clock by default, general_io_pin_two on request
    assign shared_pin_o = gpioMode ? pinControl[`GPIO_OUT_BIT] : system_clock_two;
    assign shared_pin_oe = gpioMode ? pinControl[`GPIO_DIR_BIT] :
        (enSync[1] & pinControl[`HALF_OUT_EN_BIT]);

    // Divided clock: toggles after oscillator_divider_one+1 source edges
    logic [DIV_WIDTH-1:0] divCount;
    logic [DIV_WIDTH-1:0] divLoad;
    logic [1:0] divRst;
    always_ff @(posedge oscillator_clock) begin
        divRst <= {divRst[0], reset};
        divLoad <= oscillator_divider_one;
        if (divRst[1]) begin
            divCount <= '0;
            divided_clock_out <= 1'b0;
        end else if (divCount >= divLoad) begin
            divCount <= '0;
            divided_clock_out <= ~divided_clock_out;
        end else begin
            divCount <= divCount + 1'b1;
        end
    end

    // Checks
    property p_strap_hold;
        @(posedge ref_clk) disable iff (reset)
        !$rose(reset) |-> $stable(boot_mode) && $stable(byte_order_mode);
    endproperty
    a_strap_hold: assert property (p_strap_hold)
        else $error("straps changed after reset");

    property p_order;
        @(posedge ref_clk) $fell(reset) |-> byte_order_mode == $past(endian_select_strap, 1);
    endproperty
    a_order: assert property (p_order)
        else $error("byte order does not match strap");

    property p_boot;
        @(posedge ref_clk) $fell(reset) |-> boot_mode == $past(boot_select_strap, 1);
    endproperty
    a_boot: assert property (p_boot)
        else $error("boot mode does not match strap");

    property p_kind;
        @(posedge ref_clk) $fell(reset) |-> strap_invalid == !$past(input_clock_kind_strap, 1);
    endproperty
    a_kind: assert property (p_kind)
        else $error("clock kind flag wrong");

    property p_cfg_write;
        @(posedge ref_clk) disable iff (reset)
        wrCfg |=> deviceConfig == {27'h0, $past(wb_dat_i[4]), 4'h0};
    endproperty
    a_cfg_write: assert property (p_cfg_write)
        else $error("configuration write not stored");

    property p_window;
        @(posedge ref_clk) disable iff (reset)
        busReq |=> (wb_ack_o == $past(wb_adr_i >= `CFG_WIN_BASE
            && wb_adr_i <= `CFG_WIN_LAST)) && (wb_ack_o != wb_err_o);
    endproperty
    a_window: assert property (p_window)
        else $error("window decode wrong");

    property p_pin;
        @(posedge ref_clk) disable iff (reset)
        !gpioMode |-> shared_pin_oe == (enSync[1] & pinControl[1]);
    endproperty
    a_pin: assert property (p_pin)
        else $error("half rate output enable wrong");

    property p_pin_clock;
        @(posedge ref_clk) disable iff (reset)
        !gpioMode |-> shared_pin_o == system_clock_two;
    endproperty
    a_pin_clock: assert property (p_pin_clock)
        else $error("shared pin not carrying clock");
endmodule

// File: rtl/strap_cfg_consts.svh
/*
 * Constants of the reset strap and clock select block: offsets, field
 * positions, reset values and the address window of the configuration word.
 * Assumes inclusion by bare name; holds definitions only.
 */
`ifndef STRAP_CFG_CONSTS_SVH
`define STRAP_CFG_CONSTS_SVH

// Address window of the device configuration register
`define CFG_WIN_BASE 32'h019C_0200
`define CFG_WIN_LAST 32'h019C_02FF
`define CFG_WIN_MASK 32'hFFFF_FF00
// Extra registers kept in the same window
`define PINCTL_OFFSET 8'h04
`define STRAPSTAT_OFFSET 8'h08
`define DIVCTL_OFFSET 8'h0C
// Field positions
`define MEMCLK_SRC_BIT 4
`define PIN_GPIO_SEL_BIT 0
`define HALF_OUT_EN_BIT 1
`define GPIO_DIR_BIT 2
`define GPIO_OUT_BIT 3
`define GPIO_IN_BIT 8
// Reset values
`define CFG_WORD_RESET 32'h0000_0000
`define PINCTL_RESET 4'h2
`define DIVCTL_RESET 8'h00
`define READ_ZERO 32'h0000_0000

`endif

// File: rtl/strap_cfg_pkg.sv
/*
 * Types shared by the strap and clock select logic.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package strap_cfg_pkg;
    typedef enum logic [1:0] {
        BOOT_EMULATION = 2'b00,
        BOOT_ROM8 = 2'b01,
        BOOT_ROM16 = 2'b10,
        BOOT_RESERVED = 2'b11
    } boot_mode_t;
    typedef enum logic {
        ORDER_BIG = 1'b0,
        ORDER_LITTLE = 1'b1
    } byte_order_t;
endpackage
